/* File: design/iair_regs.v */
/*
  Sensor edge interrupt masks and status, reference clock measurement and
  the indirect access window (control, address, data) with strobes.
  Assumes a one-cycle register read/write port from the serial control
  slave, per-port sensor status from the receive ports, and target blocks
  answering reads combinationally on ind_rdata for the strobed address.
*/
//
// Contract
// RULE1 - Masked rising status edges latch rise interrupts
// RULE2 - Masked falling status edges latch fall interrupts
// RULE3 - Mask registers per port, chosen by port select
// RULE4 - Reference clock measured as whole megahertz
// RULE5 - Host reads measurement twice, accepts equal pair
// RULE6 - Target select field routes indirect accesses
// RULE7 - Code 0110 writes both receive port blocks
// RULE8 - Auto-increment bumps address after each access
// RULE9 - Address write strobes prefetch when read set
// RULE10 - Data read strobes next address when both set
// RULE11 - Read bit needed only for prefetching blocks
// RULE12 - Address register holds eight-bit target offset
// RULE13 - Data write writes byte into target register
// RULE14 - Data read returns target register contents
// RULE15 - Latched status stays until cleared, drives interrupt
`timescale 1ns/1ps
`include "iair_map.vh"

module iair_regs (
  core_clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  port_sel,
  sensor_status_bits,
  reference_clock_input,
  ind_addr,
  ind_wdata,
  ind_wr_strb,
  ind_rd_strb,
  ind_rdata,
  irq_out
);
  input wire core_clk;
  input wire rst_n;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output wire [7:0] reg_rdata;
  input wire port_sel;
  input wire [15:0] sensor_status_bits;
  input wire reference_clock_input;
  output reg [7:0] ind_addr;
  output reg [7:0] ind_wdata;
  output reg [7:0] ind_wr_strb;
  output reg [7:0] ind_rd_strb;
  input wire [7:0] ind_rdata;
  output reg irq_out;

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_sync_n;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_sync_n = rst_s2_r;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire hit_rise = (reg_addr == `IAIR_OFS_RISE_MASK);
  wire hit_fall = (reg_addr == `IAIR_OFS_FALL_MASK);
  wire hit_ctl = (reg_addr == `IAIR_OFS_IND_CTL);
  wire hit_addr = (reg_addr == `IAIR_OFS_IND_ADDR);
  wire hit_data = (reg_addr == `IAIR_OFS_IND_DATA);
  wire hit_rsts = (reg_addr == `IAIR_OFS_RISE_STS);
  wire hit_fsts = (reg_addr == `IAIR_OFS_FALL_STS);

  // --------------------------------------------------------------------
  // Per-port masks and edge interrupt status
  // --------------------------------------------------------------------
  reg [7:0] rise_mask_r [0:1];
  reg [7:0] fall_mask_r [0:1];
  reg [7:0] rise_sts_r [0:1];
  reg [7:0] fall_sts_r [0:1];
  reg [15:0] sen_m1_r;
  reg [15:0] sen_m2_r;
  reg [15:0] sen_m3_r;
  reg [15:0] sen_stable_r;
  reg [15:0] sen_prev_r;
  wire [15:0] sen_agree = ~(sen_m2_r ^ sen_m3_r);
  wire [15:0] sen_next = (sen_agree & sen_m3_r) | (~sen_agree & sen_stable_r);
  integer p;

  // Status arrives from receive-port logic on other clocks, so it is
  // filtered: a change counts once the second and third stages agree.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sen_m1_r <= 16'h0000;
      sen_m2_r <= 16'h0000;
      sen_m3_r <= 16'h0000;
      sen_stable_r <= 16'h0000;
      sen_prev_r <= 16'h0000;
    end else begin
      sen_m1_r <= sensor_status_bits;
      sen_m2_r <= sen_m1_r;
      sen_m3_r <= sen_m2_r;
      sen_stable_r <= sen_next;
      sen_prev_r <= sen_stable_r;
    end
  end

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (p = 0; p < 2; p = p + 1) begin
        rise_mask_r[p] <= `IAIR_RST_BYTE;
        fall_mask_r[p] <= `IAIR_RST_BYTE;
        rise_sts_r[p] <= `IAIR_RST_BYTE;
        fall_sts_r[p] <= `IAIR_RST_BYTE;
      end
    end else begin
      if (reg_wr && hit_rise)
        rise_mask_r[port_sel] <= reg_wdata; // RULE3
      if (reg_wr && hit_fall)
        fall_mask_r[port_sel] <= reg_wdata; // RULE3
      for (p = 0; p < 2; p = p + 1) begin
        // Read clears; a new edge in the same cycle wins over the clear
        rise_sts_r[p] <= ((reg_rd && hit_rsts && port_sel == p) ?
          8'h00 : rise_sts_r[p]) |
          (rise_mask_r[p] & sen_stable_r[p*8 +: 8] &
           ~sen_prev_r[p*8 +: 8]); // RULE1 RULE15
        fall_sts_r[p] <= ((reg_rd && hit_fsts && port_sel == p) ?
          8'h00 : fall_sts_r[p]) |
          (fall_mask_r[p] & ~sen_stable_r[p*8 +: 8] &
           sen_prev_r[p*8 +: 8]); // RULE2 RULE15
      end
    end
  end

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      irq_out <= 1'b0;
    else
      irq_out <= |{rise_sts_r[0], rise_sts_r[1],
                   fall_sts_r[0], fall_sts_r[1]}; // RULE15
  end

  // --------------------------------------------------------------------
  // Reference clock measurement
  // --------------------------------------------------------------------
  // Rising edges of the reference are counted over a 1 us gate, which
  // gives megahertz directly. Only references well below half the core
  // clock can be resolved this way.
  reg [2:0] ref_sync_r;
  reg [5:0] gate_cnt_r;
  reg [7:0] edge_cnt_r;
  reg [7:0] mhz_r;
  wire ref_rise = ref_sync_r[1] & ~ref_sync_r[2];

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_sync_r <= 3'b000;
      gate_cnt_r <= 6'h00;
      edge_cnt_r <= 8'h00;
      mhz_r <= `IAIR_RST_BYTE;
    end else begin
      ref_sync_r <= {ref_sync_r[1:0], reference_clock_input};
      if (gate_cnt_r == `IAIR_GATE_CYC - 1) begin
        gate_cnt_r <= 6'h00;
        mhz_r <= edge_cnt_r + {7'h00, ref_rise}; // RULE4
        edge_cnt_r <= 8'h00;
      end else begin
        gate_cnt_r <= gate_cnt_r + 6'h01;
        if (ref_rise && edge_cnt_r != 8'hff)
          edge_cnt_r <= edge_cnt_r + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Indirect access window
  // --------------------------------------------------------------------
  reg [7:0] ctl_r;
  reg wr_inc_r;
  wire [3:0] tgt_sel = ctl_r[`IAIR_CTL_SEL_MSB:`IAIR_CTL_SEL_LSB];
  wire ainc = ctl_r[`IAIR_CTL_AINC_BIT];
  wire pref = ctl_r[`IAIR_CTL_READ_BIT];
  reg [7:0] tgt_onehot;

  // Target code to block strobe lines: bit0 pattern gen, 1 rx0, 2 rx1,
  // 5 shared rx, 7 CSI; reserved codes reach nothing.
  always @* begin
    tgt_onehot = 8'h00;
    if (tgt_sel == `IAIR_TGT_PATGEN)
      tgt_onehot = 8'h01; // RULE6
    else if (tgt_sel == `IAIR_TGT_RX0)
      tgt_onehot = 8'h02; // RULE6
    else if (tgt_sel == `IAIR_TGT_RX1)
      tgt_onehot = 8'h04; // RULE6
    else if (tgt_sel == `IAIR_TGT_RX_SHARED)
      tgt_onehot = 8'h20; // RULE6
    else if (tgt_sel == `IAIR_TGT_CSI)
      tgt_onehot = 8'h80; // RULE6
  end

  // Broadcast code reaches both receive port blocks for writes only
  wire [7:0] wr_onehot = (tgt_sel == `IAIR_TGT_RX_BOTH) ?
    8'h06 : tgt_onehot; // RULE7
  wire data_wr = reg_wr && hit_data;
  wire data_rd = reg_rd && hit_data;

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctl_r <= `IAIR_RST_BYTE;
      ind_addr <= `IAIR_RST_BYTE;
      wr_inc_r <= 1'b0;
      ind_wdata <= `IAIR_RST_BYTE;
      ind_wr_strb <= 8'h00;
      ind_rd_strb <= 8'h00;
    end else begin
      ind_wr_strb <= 8'h00;
      ind_rd_strb <= 8'h00;
      wr_inc_r <= data_wr && ainc;
      // Write strobe must meet the old address, so its bump waits a cycle;
      // a data read in that very cycle still sees the old address
      if (wr_inc_r)
        ind_addr <= ind_addr + 8'h01; // RULE8
      if (reg_wr && hit_ctl)
        ctl_r <= reg_wdata & `IAIR_CTL_WR_MASK;
      if (reg_wr && hit_addr) begin
        ind_addr <= reg_wdata; // RULE12
        if (pref)
          ind_rd_strb <= tgt_onehot; // RULE9
      end
      if (data_wr) begin
        ind_wdata <= reg_wdata;
        ind_wr_strb <= wr_onehot; // RULE13
      end
      if (data_rd && ainc) begin
        ind_addr <= ind_addr + 8'h01; // RULE8
        if (pref)
          ind_rd_strb <= tgt_onehot; // RULE10
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  reg [7:0] rdata_mux;

  always @* begin
    rdata_mux = 8'h00;
    if (hit_rise)
      rdata_mux = rise_mask_r[port_sel]; // RULE3
    else if (hit_fall)
      rdata_mux = fall_mask_r[port_sel];
    else if (reg_addr == `IAIR_OFS_REFERENCE_CLOCK_INPUT_MHZ)
      rdata_mux = mhz_r; // RULE4
    else if (hit_ctl)
      rdata_mux = ctl_r;
    else if (hit_addr)
      rdata_mux = ind_addr;
    else if (hit_data)
      rdata_mux = ind_rdata; // RULE14
    else if (hit_rsts)
      rdata_mux = rise_sts_r[port_sel];
    else if (hit_fsts)
      rdata_mux = fall_sts_r[port_sel];
  end
  assign reg_rdata = rdata_mux;

endmodule

/* File: include/iair_map.vh */
/*
  Register offsets, field positions, reset values and target codes for the
  indirect access and sensor edge interrupt register slice.
  Assumes an 8-bit register address space reached through a local
  register port of the device's serial control interface.
*/
`ifndef IAIR_MAP_VH
`define IAIR_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IAIR_OFS_RISE_MASK 8'h7e
`define IAIR_OFS_FALL_MASK 8'h7f
`define IAIR_OFS_RSVD_A0_LO 8'ha0
`define IAIR_OFS_RSVD_A0_HI 8'ha4
`define IAIR_OFS_REFERENCE_CLOCK_INPUT_MHZ 8'ha5
`define IAIR_OFS_RSVD_A7_LO 8'ha7
`define IAIR_OFS_RSVD_A7_HI 8'haf
`define IAIR_OFS_IND_CTL 8'hb0
`define IAIR_OFS_IND_ADDR 8'hb1
`define IAIR_OFS_IND_DATA 8'hb2
`define IAIR_OFS_RISE_STS 8'hc0
`define IAIR_OFS_FALL_STS 8'hc1

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define IAIR_CTL_READ_BIT 0
`define IAIR_CTL_AINC_BIT 1
`define IAIR_CTL_SEL_LSB 2
`define IAIR_CTL_SEL_MSB 5
`define IAIR_CTL_WR_MASK 8'h3f
`define IAIR_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// Indirect target codes
// ----------------------------------------------------------------------
`define IAIR_TGT_PATGEN 4'h0
`define IAIR_TGT_RX0 4'h1
`define IAIR_TGT_RX1 4'h2
`define IAIR_TGT_RX_SHARED 4'h5
`define IAIR_TGT_RX_BOTH 4'h6
`define IAIR_TGT_CSI 4'h7

// ----------------------------------------------------------------------
// Reference clock measurement
// ----------------------------------------------------------------------
`define IAIR_TICK_NS 1000
`define IAIR_CLK_NS 20
`define IAIR_GATE_CYC (`IAIR_TICK_NS / `IAIR_CLK_NS)

`endif

/* File: sim/iair_regs_monitor.sv */
/*
  Port checker for the indirect window and the interrupt output.
  Assumes it is bound onto iair_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "iair_map.vh"
module iair_regs_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] ind_addr,
  input wire [7:0] ind_wdata,
  input wire [7:0] ind_wr_strb,
  input wire [7:0] ind_rd_strb,
  input wire [7:0] ind_rdata,
  input wire irq_out
);
  // Shadow of the control byte; bits 7:6 never stick
  reg [7:0] ctl_r;
  wire [3:0] sel = ctl_r[5:2];
  wire sel_ok = sel < 4'h3 || sel == 4'h5 || sel == 4'h7;
  wire [7:0] tgt = sel_ok ? 8'h01 << sel : 8'h00;
  wire wr_a = reg_wr && reg_addr == `IAIR_OFS_IND_ADDR;
  wire wr_d = reg_wr && reg_addr == `IAIR_OFS_IND_DATA;
  wire rd_d = reg_rd && reg_addr == `IAIR_OFS_IND_DATA;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ctl_r <= 8'h00;
    else if (reg_wr && reg_addr == `IAIR_OFS_IND_CTL)
      ctl_r <= reg_wdata & 8'h3f;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_addr_load: assert property (
    wr_a |=> ind_addr == $past(reg_wdata)) else $error("address not loaded");
  chk_data_write: assert property (
    wr_d && sel != 4'h6 |=> ind_wr_strb == tgt &&
    ind_wdata == $past(reg_wdata)) else $error("bad write strobe");
  chk_both_ports: assert property (
    wr_d && sel == 4'h6 |=> ind_wr_strb == 8'h06) else $error("no dual write");
  chk_prefetch_strobe: assert property (
    wr_a |=> ind_rd_strb == (ctl_r[0] ? tgt : 8'h00))
    else $error("bad prefetch strobe");
  chk_auto_incr: assert property (
    rd_d && ctl_r[1] |=> ind_addr == $past(ind_addr) + 8'h01)
    else $error("address not incremented");
  chk_write_incr: assert property (
    wr_d && ctl_r[1] |=> ind_addr == $past(ind_addr) ##1
    ind_addr == $past(ind_addr, 2) + 8'h01)
    else $error("write address not kept then incremented");
  chk_read_next: assert property (
    rd_d && ctl_r[1:0] == 2'b11 |=> ind_rd_strb == tgt)
    else $error("no next-address strobe");
  chk_read_data: assert property (
    rd_d |-> reg_rdata == ind_rdata) else $error("bad indirect read data");
  chk_ctl_read: assert property (
    reg_rd && reg_addr == `IAIR_OFS_IND_CTL |-> reg_rdata == ctl_r)
    else $error("bad control readback");
  chk_irq_hold: assert property (
    irq_out && !reg_rd && !$past(reg_rd) |=> irq_out)
    else $error("interrupt dropped without read");
endmodule

bind iair_regs iair_regs_monitor u_mon (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ind_addr, .ind_wdata,
  .ind_wr_strb, .ind_rd_strb, .ind_rdata, .irq_out);

/* File: sim/iair_regs_tb.sv */
/*
  Self-checking bench for iair_regs.
  Assumes the target model answers the indirect window.
*/
`timescale 1ns/1ps
`include "iair_map.vh"
`define CHK_EQ(got, exp) begin \
  checked = checked + 1; \
  if ((got) !== (exp)) begin \
    mismatches = mismatches + 1; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); \
  end \
end
module iair_regs_tb;
  localparam [47:0] OFS = 48'h7e7f_a0a7_b010;
  localparam [23:0] CODES = 24'h7652_10;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg port_sel = 1'b0;
  reg [15:0] sensor_status_bits = 16'h0002;
  reg reference_clock_input = 1'b0;
  wire [7:0] reg_rdata, ind_addr, ind_wdata, ind_wr_strb, ind_rd_strb;
  wire [7:0] ind_rdata;
  wire irq_out;
  integer mismatches = 0;
  integer checked = 0;
  integer n, k;
  reg [7:0] exp_q [$];
  reg [7:0] a, d, ex_w;

  iair_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_sel(port_sel),
    .sensor_status_bits(sensor_status_bits),
    .reference_clock_input(reference_clock_input), .ind_addr(ind_addr),
    .ind_wdata(ind_wdata), .ind_wr_strb(ind_wr_strb),
    .ind_rd_strb(ind_rd_strb), .ind_rdata(ind_rdata), .irq_out(irq_out));
  iair_target_model u_tgt (.core_clk(core_clk), .ind_addr(ind_addr),
    .ind_wdata(ind_wdata), .ind_wr_strb(ind_wr_strb),
    .ind_rdata(ind_rdata));

  always #10 core_clk = ~core_clk;
  // 5 MHz, offset so its edges never meet the core clock edges
  initial #3 forever #100 reference_clock_input = ~reference_clock_input;

  // One host byte access; an idle edge follows so strobes never abut
  task acc(input w, input [7:0] ad, input [7:0] dt);
    begin
      if (!w)
        exp_q.push_back(dt);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  always @(posedge core_clk) begin
    if (reg_rd) begin
      ex_w = exp_q.pop_front();
      `CHK_EQ(reg_rdata, ex_w)
    end
  end

  task tally_and_finish;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    n = $urandom(32'h814c);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (n = 0; n < 6; n = n + 1)
      acc(0, OFS[8*n +: 8], 8'h00);
    acc(1, 8'ha7, 8'hff);
    acc(1, 8'hb0, 8'hff);
    acc(0, 8'ha7, 8'h00);
    acc(0, 8'hb0, 8'h3f);
    port_sel <= 1'b1;
    acc(1, 8'h7e, 8'ha5);
    acc(1, 8'h7f, 8'h3c);
    port_sel <= 1'b0;
    acc(1, 8'h7e, 8'h01);
    acc(1, 8'h7f, 8'h02);
    acc(0, 8'h7e, 8'h01);
    port_sel <= 1'b1;
    acc(0, 8'h7e, 8'ha5);
    acc(0, 8'h7f, 8'h3c);
    port_sel <= 1'b0;
    // Bit 0 rises, bit 1 falls, bit 2 rises unmasked
    sensor_status_bits <= 16'h0005;
    k = 0;
    while (irq_out !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k = k + 1;
    end
    if (k == 20) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
    repeat (5) @(posedge core_clk);
    `CHK_EQ(irq_out, 1'b1)
    acc(0, 8'hc0, 8'h01);
    acc(0, 8'hc1, 8'h02);
    acc(0, 8'hc0, 8'h00);
    `CHK_EQ(irq_out, 1'b0)
    // Port 1 bits 2 and 5 rise under its own rise mask only
    sensor_status_bits <= 16'h2405;
    repeat (10) @(posedge core_clk);
    acc(0, 8'hc0, 8'h00);
    port_sel <= 1'b1;
    acc(0, 8'hc0, 8'h24);
    acc(0, 8'hc1, 8'h00);
    port_sel <= 1'b0;
    acc(0, 8'ha5, 8'h05);
    acc(0, 8'ha5, 8'h05);
    for (n = 0; n < 6; n = n + 1) begin
      a = $urandom;
      d = $urandom;
      acc(1, 8'hb0, {2'b00, CODES[4*n +: 4], 2'b11});
      acc(1, 8'hb1, a);
      acc(1, 8'hb2, d);
      acc(0, 8'hb1, a + 8'h01);
      acc(1, 8'hb1, a);
      acc(0, 8'hb2, d);
      acc(0, 8'hb1, a + 8'h01);
    end
    acc(1, 8'hb0, 8'h06);
    acc(1, 8'hb1, a);
    acc(0, 8'hb2, d);
    repeat (2) @(posedge core_clk);
    tally_and_finish;
  end
endmodule

/* File: sim/iair_target_model.sv */
/*
  Target register blocks behind the indirect window.
  Assumes all targets share one 256-byte space; reads are combinational.
*/
`timescale 1ns/1ps
module iair_target_model (
  input wire core_clk,
  input wire [7:0] ind_addr,
  input wire [7:0] ind_wdata,
  input wire [7:0] ind_wr_strb,
  output wire [7:0] ind_rdata
);
  reg [7:0] mem [0:255];
  integer i;
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = ~i[7:0];
  end
  always @(posedge core_clk) begin
    if (|ind_wr_strb)
      mem[ind_addr] <= ind_wdata;
  end
  assign ind_rdata = mem[ind_addr];
endmodule
